// ==== smbc_assertions.sv ====
// Purpose: wire-level checks of the clock-config link
// Assumes: controller built with QDIV 4, so scl spans are fixed
// Notes: all checks sampled on the controller clock that makes scl
`timescale 1ns/10ps
module smbc_assertions (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic scl,
   input wire logic host_sda_o,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic sda
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   ////////////////////////////////////////////////////////////////////
   // scl high phase of one symbol, two quarters of four cycles
   sequence s_high_hold;
      scl [*8];
   endsequence
   // both ends may pull together only while scl is low (ack hand-over)
   property p_pins_low; !host_sda_o && !dev_sda_o && !(scl && host_sda_oe && dev_sda_oe); endproperty
   property p_dev_stable; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
   property p_start_host; scl && $past(scl) && $fell(sda) |-> $rose(host_sda_oe); endproperty
   property p_scl_high; $rose(scl) |-> s_high_hold; endproperty
   property p_scl_low; $fell(scl) |-> !scl [*4]; endproperty
   property p_stop_quiet; scl && $past(scl) && $rose(sda) |-> !dev_sda_oe [*8]; endproperty
   property p_dev_rise; $rose(dev_sda_oe) |-> !scl; endproperty
   property p_host_hold; scl && $past(scl) && $stable(sda) |-> $stable(host_sda_oe); endproperty
   a_pins_low: assert property (p_pins_low) else $error("sda driven high or both ends pull in a bit");
   a_dev_stable: assert property (p_dev_stable) else $error("device moved sda with scl high");
   a_start_host: assert property (p_start_host) else $error("start not made by controller");
   a_scl_high: assert property (p_scl_high) else $error("scl high phase too short");
   a_scl_low: assert property (p_scl_low) else $error("scl low phase too short");
   a_stop_quiet: assert property (p_stop_quiet) else $error("device drives after stop");
   a_dev_rise: assert property (p_dev_rise) else $error("device ack begun with scl high");
   a_host_hold: assert property (p_host_hold) else $error("controller moved sda in bit");
endmodule // smbc_assertions

// ==== smbc_defs.svh ====
// Purpose: shared constants of the clock-config serial link
// Assumes: included by bare name
// Notes: offsets, fields, resets and timing figures
`ifndef SMBC_DEFS_SVH
`define SMBC_DEFS_SVH
// link addressing and command byte
`define SMBC_DEV_ADDR 7'h69
`define SMBC_CMD_BYTE_BIT 7
`define SMBC_IDX_FREQ 7'h00
`define SMBC_IDX_CPU 7'h01
`define SMBC_IDX_SLOT 7'h02
// byte 0 field positions
`define SMBC_B0_SEL_HI 7
`define SMBC_B0_SEL_LO 4
`define SMBC_B0_OVR 3
`define SMBC_B0_SEL4 2
`define SMBC_B0_SSC 1
// byte 1 and 2 fields
`define SMBC_B1_PAIR_LO 5
`define SMBC_B2_SLOT_HI 6
// reset values
`define SMBC_SEL_RST 5'h00
`define SMBC_PAIR_RST 3'h7
`define SMBC_SLOT_RST 7'h7F
// controller register map (byte addresses)
`define SMBC_REG_CTRL 4'h0
`define SMBC_REG_WDATA 4'h4
`define SMBC_REG_STAT 4'h8
`define SMBC_CTRL_GO 0
`define SMBC_CTRL_RD 1
`define SMBC_CTRL_IDX_LO 8
`define SMBC_RESP_OKAY 2'h0
`define SMBC_RESP_SLVERR 2'h2
// timing
`define SMBC_CLK_PERIOD_NS 40
`define SMBC_SCL_PERIOD_NS 10000
`define SMBC_ACK_SLOT 4'h8
`endif

// ==== smbc_dev.sv ====
// Purpose: serial slave holding clock configuration bytes 0 to 2
// Assumes: link_clk_i far faster than scl; straps stable at reset release
// Notes: block transfers acknowledged at command, then ignored
//
// Overview of operation
// - start, address, write bit, device acknowledges
// - command top bit one, low bits index
// - write data byte acknowledged, stored, then stop
// - read uses repeated start, read address acknowledged
// - device sends byte; host nacks then stops
// - byte 0 holds software frequency code
// - override bit picks straps or software code
// - byte 0 bit 1 enables spread spectrum
// - byte 1 low bits report latched straps
// - writes to latched strap bits ignored
// - respond only to own seven-bit address
// - command top bit zero means block transfer
`timescale 1ns/10ps
`include "smbc_defs.svh"
module smbc_dev
   import smbc_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = `SMBC_DEV_ADDR
) (
   input wire logic link_clk_i,
   input wire logic sys_rst_i,
   smbc_link_if.dev link,
   input wire logic [4:0] strap_freq_inputs_i,
   output logic [4:0] freq_select_o,
   output logic freq_source_override_o,
   output logic spread_enable_o,
   output logic [2:0] proc_clock_pair_en_o,
   output logic [6:0] slot_clock_en_o,
   output logic [4:0] latched_strap_o
);

   initial begin
      if (DEV_ADDR == 7'h00) begin
         $error("smbc_dev: general call address not allowed");
      end
   end

   ////////////////////////////////////////////////////////////////////
   // declarations
   logic rst_meta_q;
   logic rst_q;
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic scl_prev_q;
   logic sda_prev_q;
   logic [4:0] strap_meta_q;
   logic [4:0] strap_s_q;
   logic [4:0] strap_lat_q;
   logic strap_taken_q;
   smbc_dev_st_t st_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic [7:0] tx_q;
   logic ack_q;
   logic oe_q;
   logic [6:0] idx_q;
   logic cmd_ok_q;
   logic [4:0] sel_q;
   logic ovr_q;
   logic ssc_q;
   logic [2:0] pair_q;
   logic [6:0] slot_q;
   logic [4:0] fsel_q;

   ////////////////////////////////////////////////////////////////////
   // reset and pin synchronisers
   // reset comes from the system domain, so it is resynchronised
   always_ff @(posedge link_clk_i) begin
      rst_meta_q <= sys_rst_i;
      rst_q <= rst_meta_q;
   end

   // two stages before any edge logic looks at the pins
   always_ff @(posedge link_clk_i) begin
      if (rst_q) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], link.scl};
         sda_sync_q <= {sda_sync_q[0], link.sda};
         scl_prev_q <= scl_sync_q[1];
         sda_prev_q <= sda_sync_q[1];
      end
   end

   // line events, all from the second stage
   wire scl_s = scl_sync_q[1];
   wire sda_s = sda_sync_q[1];
   wire scl_rise = scl_s & ~scl_prev_q;
   wire scl_fall = ~scl_s & scl_prev_q;
   wire start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   wire stop_ev = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   ////////////////////////////////////////////////////////////////////
   // strap capture
   // latch once after reset release
   always_ff @(posedge link_clk_i) begin
      strap_meta_q <= strap_freq_inputs_i;
      strap_s_q <= strap_meta_q;
      if (rst_q) begin
         strap_taken_q <= 1'b0;
      end else if (!strap_taken_q) begin
         strap_taken_q <= 1'b1;
         strap_lat_q <= strap_s_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // decode of the received byte and read data
   // only our address, direction in bit 0
   wire addr_hit = (sh_q[7:1] == DEV_ADDR);
   wire rx_dir_rd = sh_q[0];
   wire cmd_byte_mode = sh_q[`SMBC_CMD_BYTE_BIT];
   wire byte_done = (cnt_q == `SMBC_ACK_SLOT) & ~ack_q;
   wire in_rx = (st_q == SMBC_DS_ADDR) | (st_q == SMBC_DS_CMD) | (st_q == SMBC_DS_WDATA);

   // reserved bit positions read as zero
   wire [7:0] byte0 = {sel_q[3:0], ovr_q, sel_q[4], ssc_q, 1'b0};
   wire [7:0] byte1 = {pair_q, strap_lat_q};
   wire [7:0] byte2 = {1'b0, slot_q};
   // unmapped indexes read as zero
   wire [7:0] rd_byte = (idx_q == `SMBC_IDX_FREQ) ? byte0 :
                        (idx_q == `SMBC_IDX_CPU) ? byte1 :
                        (idx_q == `SMBC_IDX_SLOT) ? byte2 : 8'h00;

   // store at the fall that ends the data byte
   wire wr_en = scl_fall & byte_done & (st_q == SMBC_DS_WDATA) & cmd_ok_q;

   ////////////////////////////////////////////////////////////////////
   // bit engine
   // bits are taken on scl rise; sda only changes on scl fall
   always_ff @(posedge link_clk_i) begin
      if (rst_q) begin
         st_q <= SMBC_DS_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         ack_q <= 1'b0;
         oe_q <= 1'b0;
         idx_q <= 7'h00;
         cmd_ok_q <= 1'b0;
      end else if (start_ev) begin
         // start or repeated start opens an address byte
         st_q <= SMBC_DS_ADDR;
         cnt_q <= 4'h0;
         ack_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (stop_ev) begin
         st_q <= SMBC_DS_IDLE;
         cmd_ok_q <= 1'b0;
         ack_q <= 1'b0;
         oe_q <= 1'b0;
         cnt_q <= 4'h0;
      end else if (scl_rise && !ack_q && st_q != SMBC_DS_IDLE) begin
         sh_q <= {sh_q[6:0], sda_s};
         cnt_q <= cnt_q + 4'h1;
      end else if (scl_fall && ack_q) begin
         // end of our acknowledge slot
         ack_q <= 1'b0;
         cnt_q <= 4'h0;
         if (st_q == SMBC_DS_RDATA) begin
            oe_q <= ~tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
         end else begin
            oe_q <= 1'b0;
         end
      end else if (scl_fall && st_q == SMBC_DS_RDATA) begin
         if (cnt_q == `SMBC_ACK_SLOT) begin
            // release for the host nack, then wait for stop
            oe_q <= 1'b0;
            st_q <= SMBC_DS_IDLE;
         end else begin
            oe_q <= ~tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end else if (scl_fall && byte_done && in_rx) begin
         case (st_q)
            SMBC_DS_ADDR: begin
               if (addr_hit && !rx_dir_rd) begin
                  ack_q <= 1'b1;
                  oe_q <= 1'b1;
                  st_q <= SMBC_DS_CMD;
               end else if (addr_hit && cmd_ok_q) begin
                  ack_q <= 1'b1;
                  oe_q <= 1'b1;
                  tx_q <= rd_byte;
                  st_q <= SMBC_DS_RDATA;
               end else begin
                  // foreign address, or our read address with no byte command before it, stay off the bus
                  st_q <= SMBC_DS_IDLE;
               end
            end
            SMBC_DS_CMD: begin
               ack_q <= 1'b1;
               oe_q <= 1'b1;
               idx_q <= sh_q[6:0];
               cmd_ok_q <= cmd_byte_mode;
               st_q <= cmd_byte_mode ? SMBC_DS_WDATA : SMBC_DS_IDLE;
            end
            SMBC_DS_WDATA: begin
               // acknowledge the data byte; later bytes ignored
               ack_q <= 1'b1;
               oe_q <= 1'b1;
               st_q <= SMBC_DS_IDLE;
            end
            default: begin
               st_q <= SMBC_DS_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // configuration bytes
   // a write lands in one cycle; freq_select_o follows one cycle later, the other outputs at once
   always_ff @(posedge link_clk_i) begin
      if (rst_q) begin
         sel_q <= `SMBC_SEL_RST;
         ovr_q <= 1'b0;
         ssc_q <= 1'b0;
         pair_q <= `SMBC_PAIR_RST;
         slot_q <= `SMBC_SLOT_RST;
      end else if (wr_en) begin
         case (idx_q)
            `SMBC_IDX_FREQ: begin
               // code bits 3..0 high nibble, bit 4 at bit 2
               sel_q <= {sh_q[`SMBC_B0_SEL4], sh_q[`SMBC_B0_SEL_HI:`SMBC_B0_SEL_LO]};
               ovr_q <= sh_q[`SMBC_B0_OVR];
               ssc_q <= sh_q[`SMBC_B0_SSC];
            end
            `SMBC_IDX_CPU: begin
               // strap bits of this byte are not writable
               pair_q <= sh_q[7:`SMBC_B1_PAIR_LO];
            end
            `SMBC_IDX_SLOT: begin
               slot_q <= sh_q[`SMBC_B2_SLOT_HI:0];
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // effective frequency selection
   // straps unless software override is set
   always_ff @(posedge link_clk_i) begin
      if (rst_q) begin
         fsel_q <= 5'h00;
      end else begin
         fsel_q <= ovr_q ? sel_q : strap_lat_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   assign freq_select_o = fsel_q;
   assign freq_source_override_o = ovr_q;
   assign spread_enable_o = ssc_q;
   assign proc_clock_pair_en_o = pair_q;
   assign slot_clock_en_o = slot_q;
   assign latched_strap_o = strap_lat_q;
   // open drain: only ever pulls low
   assign link.dev_sda_o = 1'b0;
   assign link.dev_sda_oe = oe_q;

endmodule // smbc_dev

// ==== smbc_host.sv ====
// Purpose: link controller for single-byte reads and writes
// Assumes: software drives it over AXI4-Lite
// Notes: scl derived from clock_i, no clock stretching
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "smbc_defs.svh"
module smbc_host
   import smbc_pkg::*;
#(
   parameter int QDIV = (`SMBC_SCL_PERIOD_NS + 4 * `SMBC_CLK_PERIOD_NS - 1) / (4 * `SMBC_CLK_PERIOD_NS),
   parameter logic [6:0] DEV_ADDR = `SMBC_DEV_ADDR
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   smbc_link_if.host link,
   input wire logic [3:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [3:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i
);

   initial begin
      if (QDIV < 4 || QDIV > 4095) begin
         $error("smbc_host: QDIV out of range");
      end
   end

   ////////////////////////////////////////////////////////////////////
   // declarations
   logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
   logic [3:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic rd_mode_q;
   logic [6:0] idx_q;
   logic [7:0] wbyte_q;
   smbc_host_st_t st_q;
   logic [11:0] qcnt_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic [1:0] byte_q;
   logic [7:0] rx_q;
   logic ack_s_q, nack_q, scl_q, oe_q;
   logic [1:0] sda_sync_q;

   ////////////////////////////////////////////////////////////////////
   // bus decode
   wire do_wr = aw_have_q & w_have_q & ~bvalid_q;
   wire wr_ctrl = do_wr & (aw_addr_q == `SMBC_REG_CTRL);
   wire wr_wdat = do_wr & (aw_addr_q == `SMBC_REG_WDATA);
   wire wr_hit = wr_ctrl | wr_wdat | (aw_addr_q == `SMBC_REG_STAT);
   wire idle = (st_q == SMBC_HS_IDLE);
   wire go = wr_ctrl & w_strb_q[0] & w_data_q[`SMBC_CTRL_GO] & idle;
   wire ar_take = s_axi_arvalid_i & ~rvalid_q;
   wire [31:0] ctrl_rd = {17'h0, idx_q, 6'h0, rd_mode_q, 1'b0};
   wire [31:0] stat_rd = {16'h0, rx_q, 6'h0, nack_q, ~idle};
   wire rd_hit = (s_axi_araddr_i == `SMBC_REG_CTRL) | (s_axi_araddr_i == `SMBC_REG_WDATA) |
                 (s_axi_araddr_i == `SMBC_REG_STAT);
   wire [31:0] rd_mux = (s_axi_araddr_i == `SMBC_REG_CTRL) ? ctrl_rd :
                        (s_axi_araddr_i == `SMBC_REG_WDATA) ? {24'h0, wbyte_q} :
                        (s_axi_araddr_i == `SMBC_REG_STAT) ? stat_rd : 32'h0;

   // address and data taken in either order, answered once both held
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `SMBC_RESP_OKAY;
         aw_addr_q <= 4'h0;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata_i;
            w_strb_q <= s_axi_wstrb_i;
         end
         if (do_wr) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `SMBC_RESP_OKAY : `SMBC_RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready_i) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // read answers one cycle after the address is taken
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= `SMBC_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_hit ? `SMBC_RESP_OKAY : `SMBC_RESP_SLVERR;
      end else if (s_axi_rready_i) begin
         rvalid_q <= 1'b0;
      end
   end

   // command fields frozen while a transfer runs
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         rd_mode_q <= 1'b0;
         idx_q <= 7'h00;
         wbyte_q <= 8'h00;
      end else if (idle) begin
         if (wr_ctrl && w_strb_q[0]) begin
            rd_mode_q <= w_data_q[`SMBC_CTRL_RD];
         end
         if (wr_ctrl && w_strb_q[1]) begin
            idx_q <= w_data_q[`SMBC_CTRL_IDX_LO +: 7];
         end
         if (wr_wdat && w_strb_q[0]) begin
            wbyte_q <= w_data_q[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // frame sequencing: write 3 bytes; read 2, repeated start, 2
   wire tick = (qcnt_q == 12'(QDIV - 1));
   wire sym_end = tick & (ph_q == 2'h3);
   wire rd_byte = rd_mode_q & (byte_q == 2'h3);
   wire last_byte = rd_mode_q ? (byte_q == 2'h3) : (byte_q == 2'h2);
   wire ack_slot = (bit_q == `SMBC_ACK_SLOT);
   // address byte, direction in bit 0; top bit one
   wire [7:0] tx_byte = (byte_q == 2'h0) ? {DEV_ADDR, 1'b0} :
                        (byte_q == 2'h1) ? {1'b1, idx_q} :
                        rd_mode_q ? {DEV_ADDR, 1'b1} : wbyte_q;
   wire tx_bit = tx_byte[~bit_q[2:0]];
   wire sda_s = sda_sync_q[1];

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         st_q <= SMBC_HS_IDLE;
         qcnt_q <= 12'h0;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         byte_q <= 2'h0;
         rx_q <= 8'h00;
         ack_s_q <= 1'b1;
         nack_q <= 1'b0;
      end else if (go) begin
         st_q <= SMBC_HS_START;
         qcnt_q <= 12'h0;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         byte_q <= 2'h0;
         nack_q <= 1'b0;
      end else if (!idle) begin
         qcnt_q <= tick ? 12'h0 : qcnt_q + 12'h1;
         if (tick) begin
            ph_q <= ph_q + 2'h1;
         end
         // sample at the end of the second high quarter, one cycle before scl falls
         if (tick && ph_q == 2'h2 && st_q == SMBC_HS_BIT) begin
            if (ack_slot) begin
               ack_s_q <= sda_s;
            end else if (rd_byte) begin
               rx_q <= {rx_q[6:0], sda_s};
            end
         end
         if (sym_end) begin
            case (st_q)
               SMBC_HS_START: begin
                  st_q <= SMBC_HS_BIT;
                  bit_q <= 4'h0;
               end
               SMBC_HS_BIT: begin
                  if (!ack_slot) begin
                     bit_q <= bit_q + 4'h1;
                  end else begin
                     bit_q <= 4'h0;
                     byte_q <= byte_q + 2'h1;
                     if (!rd_byte && ack_s_q) begin
                        nack_q <= 1'b1;
                        st_q <= SMBC_HS_STOP;
                     end else if (last_byte) begin
                        // stop after write data; after nack
                        st_q <= SMBC_HS_STOP;
                     end else if (rd_mode_q && byte_q == 2'h1) begin
                        st_q <= SMBC_HS_START;
                     end
                  end
               end
               SMBC_HS_STOP: begin
                  st_q <= SMBC_HS_IDLE;
               end
               default: begin
                  st_q <= SMBC_HS_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin levels per quarter; sda moves with scl high only for start and stop
   // data bits and ack slot of the read byte released (nack)
   wire bit_oe = ~ack_slot & ~rd_byte & ~tx_bit;
   wire scl_nx = (st_q == SMBC_HS_START) ? (ph_q == 2'h1 || ph_q == 2'h2) :
                 (st_q == SMBC_HS_BIT) ? (ph_q == 2'h1 || ph_q == 2'h2) :
                 (st_q == SMBC_HS_STOP) ? (ph_q != 2'h0) : 1'b1;
   wire oe_nx = (st_q == SMBC_HS_START) ? ph_q[1] :
                (st_q == SMBC_HS_BIT) ? bit_oe :
                (st_q == SMBC_HS_STOP) ? ~ph_q[1] : 1'b0;

   // outputs from flops; sda input through two stages
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         scl_q <= 1'b1;
         oe_q <= 1'b0;
         sda_sync_q <= 2'h3;
      end else begin
         scl_q <= scl_nx;
         oe_q <= oe_nx;
         sda_sync_q <= {sda_sync_q[0], link.sda};
      end
   end

   assign link.scl = scl_q;
   assign link.host_sda_o = 1'b0;
   assign link.host_sda_oe = oe_q;
   assign s_axi_awready_o = ~aw_have_q & ~bvalid_q;
   assign s_axi_wready_o = ~w_have_q & ~bvalid_q;
   assign s_axi_bvalid_o = bvalid_q;
   assign s_axi_bresp_o = bresp_q;
   assign s_axi_arready_o = ~rvalid_q;
   assign s_axi_rvalid_o = rvalid_q;
   assign s_axi_rdata_o = rdata_q;
   assign s_axi_rresp_o = rresp_q;

endmodule // smbc_host

// ==== smbc_link_if.sv ====
// Purpose: two-wire link between controller and clock device
// Assumes: scl pushed by the controller, sda open drain
// Notes: sda level resolved here from both enables
`timescale 1ns/10ps
interface smbc_link_if;
   logic scl;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic sda;
   // wired-and with pull-up
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
   modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
   modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface // smbc_link_if

// ==== smbc_pkg.sv ====
// Purpose: types shared by both ends of the clock-config link
// Assumes: nothing
// Notes: one-hot state codes
package smbc_pkg;
   typedef enum logic [4:0] {
      SMBC_DS_IDLE = 5'h01,
      SMBC_DS_ADDR = 5'h02,
      SMBC_DS_CMD = 5'h04,
      SMBC_DS_WDATA = 5'h08,
      SMBC_DS_RDATA = 5'h10
   } smbc_dev_st_t;
   typedef enum logic [3:0] {
      SMBC_HS_IDLE = 4'h1,
      SMBC_HS_START = 4'h2,
      SMBC_HS_BIT = 4'h4,
      SMBC_HS_STOP = 4'h8
   } smbc_host_st_t;
endpackage

// ==== smbc_tb.sv ====
// Purpose: self-checking bench of controller and clock device
// Assumes: controller QDIV 4; bready and rready held high
// Notes: read results queued by the driver, checked by a monitor
`timescale 1ns/10ps
`include "smbc_defs.svh"
module testbench;
   logic clock_i = 1'b0, link_clk = 1'b0, sys_rst_i = 1'b1;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic awready, wready, bvalid, arready, rvalid, ovr, ssc;
   logic [1:0] bresp, rresp;
   logic [4:0] strap = 5'h00, fsel, lat;
   logic [2:0] pair;
   logic [6:0] slot;
   logic [17:0] exp_q[$];
   integer seed = 32'h3579, num_errors = 0, n_tests = 0;
   smbc_link_if link_if();
   smbc_host #(.QDIV(4)) u_smbc_host (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .link(link_if),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(1'b1));
   smbc_dev u_smbc_dev (.link_clk_i(link_clk), .sys_rst_i(sys_rst_i), .link(link_if),
      .strap_freq_inputs_i(strap), .freq_select_o(fsel), .freq_source_override_o(ovr), .spread_enable_o(ssc),
      .proc_clock_pair_en_o(pair), .slot_clock_en_o(slot), .latched_strap_o(lat));
   smbc_assertions u_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .scl(link_if.scl),
      .host_sda_o(link_if.host_sda_o), .host_sda_oe(link_if.host_sda_oe), .dev_sda_o(link_if.dev_sda_o),
      .dev_sda_oe(link_if.dev_sda_oe), .sda(link_if.sda));
   ////////////////////////////////////////////////////////////////////
   // clocks, the link one offset so the phases never line up
   initial begin
      forever #20 clock_i = ~clock_i;
   end
   initial begin
      #1.7;
      forever #3 link_clk = ~link_clk;
   end
   task chk(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         num_errors++;
         $display("MISMATCH %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task print_verdict();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ready sampled at negedge, so it equals what the rising edge sees
   task wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw, tbv;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      tbv = 1'b0;
      while (!tbv) begin
         @(negedge clock_i);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tbv = bvalid;
         r = bresp;
         @(posedge clock_i);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
   endtask
   task rd(input logic [3:0] a, output logic [31:0] d);
      logic tr, tv;
      araddr <= a;
      arvalid <= 1'b1;
      tv = 1'b0;
      while (!tv) begin
         @(negedge clock_i);
         tr = arvalid & arready;
         tv = rvalid;
         d = rdata;
         @(posedge clock_i);
         if (tr) arvalid <= 1'b0;
      end
   endtask
   // one link transfer, then wait for the controller to go idle
   task op(input logic rdb, input logic [6:0] idx, input logic [7:0] d);
      logic [31:0] s;
      logic [1:0] r;
      wr(`SMBC_REG_WDATA, {24'h0, d}, r);
      wr(`SMBC_REG_CTRL, {17'h0, idx, 6'h0, rdb, 1'b1}, r);
      s = 32'h1;
      while (s[0] !== 1'b0) rd(`SMBC_REG_STAT, s);
   endtask
   // monitor: oldest queued note against each read answer seen while a note is queued
   always @(negedge clock_i) begin
      if (rvalid === 1'b1 && exp_q.size() > 0) chk({rresp, rdata[15:0]}, exp_q.pop_front());
   end
   initial begin
      repeat (60000) @(posedge clock_i);
      num_errors++;
      print_verdict();
   end
   initial begin
      logic [1:0] r;
      logic [7:0] w;
      logic [7:0] m[4];
      logic [31:0] s;
      int k, i;
      strap <= 5'($random(seed));
      repeat (8) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      chk({fsel, ovr, ssc, pair, slot, lat}, {strap, 2'b00, 3'h7, 7'h7F, strap});
      m = '{8'h00, {3'h7, strap}, 8'h7F, 8'h00};
      // pass 0 reads reset values, later passes write then read back
      for (k = 0; k < 3; k++) begin
         for (i = 0; i < 4; i++) begin
            if (k > 0) begin
               w = 8'($random(seed));
               w[3] = (k == 1);
               op(1'b0, i[6:0], w);
               m[i] = (i == 0) ? w & 8'hFE : (i == 1) ? {w[7:5], strap} : (i == 2) ? w & 8'h7F : 8'h00;
            end
            op(1'b1, i[6:0], 8'h00);
            exp_q.push_back({2'h0, m[i], 8'h00});
            rd(`SMBC_REG_STAT, s);
         end
         chk({fsel, ovr, ssc, pair, slot}, {m[0][3] ? {m[0][2], m[0][7:4]} : strap, m[0][3], m[0][1],
            m[1][7:5], m[2][6:0]});
      end
      // unmapped controller address
      wr(4'hC, 32'h0, r);
      chk({30'h0, r}, {30'h0, `SMBC_RESP_SLVERR});
      exp_q.push_back({`SMBC_RESP_SLVERR, 16'h0});
      rd(4'hC, s);
      repeat (4) @(posedge clock_i);
      print_verdict();
   end
endmodule // testbench
